// ===== hw/bird_pkg.sv
package bird_pkg;

  // read locations in the processor i/o space
  localparam logic [7:0] ADDR_UNIV = 8'h80;
  localparam logic [7:0] ADDR_MISC = 8'h81;
  localparam logic [7:0] ADDR_DIG = 8'h88;
  localparam logic [7:0] ADDR_WATCHDOG = 8'h98;
  localparam logic [7:0] ADDR_EXP_FIRST = 8'hC0;
  localparam logic [7:0] ADDR_EXP_SECOND = 8'hC2;
  localparam logic [7:0] ADDR_EXP_UNUSED = 8'hC4;
  localparam logic [7:0] ADDR_EXP_RESET = 8'hC6;
  localparam logic [7:0] ADDR_DISP_CTRL = 8'hD0;
  localparam logic [7:0] ADDR_DISP_DATA = 8'hD1;

  // field positions inside the returned bytes
  localparam int UNIV_LSB = 0;
  localparam int UNIV_W = 6;
  localparam int HG_BIT = 6;
  localparam int JUMPER_BIT = 7;
  localparam int EE_BIT = 0;
  localparam int PFAIL_BIT = 1;
  localparam int KEY_LSB = 2;
  localparam int KEY_W = 6;
  localparam int DIG_LSB = 0;
  localparam int DIG_W = 7;
  localparam int UNIV8_BIT = 7;

  // values after reset
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [39:0] RST_PINS = 40'h00_0000_0000;
  localparam logic [8:0] RST_BUS = 9'h100; // read strobe idle high

  // pulse lengths in ref_clk cycles
  localparam int WATCHDOG_KICK_CYCLES = 1;
  localparam int EXP_RST_CYCLES = 16;

  // board input lines, sampled together
  typedef struct packed {
    logic [5:0] univ;
    logic hg_cmp;
    logic user_jumper_flag;
    logic ee_sda;
    logic power_fail;
    logic [5:0] key_col;
    logic [6:0] dig;
    logic univ8_cmp;
    logic [7:0] exp_data;
    logic [7:0] disp_data;
  } bird_pins_t;

  // processor i/o read strobe and address
  typedef struct packed {
    logic rd_n;
    logic [7:0] addr;
  } bird_bus_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_ACTIVE = 1'b1
  } bird_state_t;

  // locations that put data on the processor bus
  function automatic logic bird_drives(input logic [7:0] a);
    case (a)
      ADDR_UNIV, ADDR_MISC, ADDR_DIG, ADDR_WATCHDOG, ADDR_EXP_FIRST,
      ADDR_EXP_SECOND, ADDR_EXP_RESET, ADDR_DISP_CTRL,
      ADDR_DISP_DATA: bird_drives = 1'b1;
      default: bird_drives = 1'b0;
    endcase
  endfunction

endpackage

// ===== hw/bird_stretch.sv
`timescale 1ns/1ps
// turns a one-cycle trigger into a pulse of LEN cycles, starting next cycle
module bird_stretch import bird_pkg::*; #(
  parameter int LEN = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // trigger in, pulse out
  input wire logic trig,
  output logic pulse
);

  localparam int CW = $clog2(LEN + 1);
  localparam logic [CW-1:0] LOAD = CW'(LEN - 1);

  logic [CW-1:0] cnt;

  // a new trigger restarts the full length
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      pulse <= 1'b0;
    end else if (trig) begin
      cnt <= LOAD;
      pulse <= 1'b1;
    end else if (cnt != '0) begin
      cnt <= cnt - CW'(1);
    end else begin
      pulse <= 1'b0;
    end
  end

endmodule // bird_stretch

// ===== hw/bird_sync.sv
`timescale 1ns/1ps
// two flip-flop synchroniser for a vector of asynchronous levels
module bird_sync import bird_pkg::*; #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // meta feeds only q; skew across bits is settled by the caller
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // bird_sync

// ===== hw/bird_top.sv
// Behaviour
// - 0x80 returns universal inputs and high-gain comparator
// - 0x80 bit 7 is jumper, low when fitted
// - 0x81 bit 0 returns eeprom data line
// - 0x81 bit 1 power fail, bits 2-7 keys
// - 0x88 bits 0-6 return digital inputs
// - 0x88 bit 7 returns universal channel 8
// - any read of 0x98 restarts watchdog
// - read of 0xC6 resets expansion bus devices
// - 0xC0 returns first expansion bus read byte
// - 0xC2 returns second expansion bus read byte
// - 0xC4 is unused, not driven
// - 0xD0 performs display control read with busy
// - 0xD1 performs display data read
`timescale 1ns/1ps
module bird_top import bird_pkg::*; #(
  parameter int EXP_RST_LEN = EXP_RST_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // processor i/o read pins
  input wire logic [7:0] io_addr,
  input wire logic io_rd_n,
  output logic [7:0] io_data_out,
  output logic io_data_oe,
  // board input lines
  input wire bird_pins_t board_in,
  // side effects of reads
  output logic watchdog_kick,
  output logic exp_bus_reset,
  // expansion bus read strobes
  output logic exp_rd_en,
  output logic exp_rd_second,
  // display module read strobes
  output logic disp_rd_en,
  output logic disp_rs
);

  bird_bus_t bus_s;
  bird_pins_t in_s;
  bird_state_t state;
  bird_state_t next_state;
  logic [7:0] addr_q;

  // pins come from the processor and the board, both asynchronous
  bird_sync #(.W(9), .RST_VAL(RST_BUS)) u_bus_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d({io_rd_n, io_addr}),
    .q(bus_s)
  );

  bird_sync #(.W(40), .RST_VAL(RST_PINS)) u_pin_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d(board_in),
    .q(in_s)
  );

  // read cycle framing: start on the synced strobe falling low
  wire rd_low = !bus_s.rd_n;
  wire rd_start = (state == ST_IDLE) && rd_low;
  wire in_read = (state == ST_ACTIVE) && rd_low;

  always_comb begin
    case (state)
      ST_IDLE: next_state = rd_low ? ST_ACTIVE : ST_IDLE;
      ST_ACTIVE: next_state = rd_low ? ST_ACTIVE : ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // address is held for the whole read so the mux cannot glitch
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      addr_q <= RST_DATA;
    end else begin
      state <= next_state;
      if (rd_start) begin
        addr_q <= bus_s.addr;
      end
    end
  end

  // assembled input ports
  wire [7:0] univ_port;
  wire [7:0] misc_port;
  wire [7:0] dig_port;

  assign univ_port[UNIV_LSB +: UNIV_W] = in_s.univ;
  assign univ_port[HG_BIT] = in_s.hg_cmp;
  // pin is pulled up, so a fitted jumper reads zero
  assign univ_port[JUMPER_BIT] = in_s.user_jumper_flag;
  assign misc_port[EE_BIT] = in_s.ee_sda;
  assign misc_port[PFAIL_BIT] = in_s.power_fail;
  assign misc_port[KEY_LSB +: KEY_W] = in_s.key_col;
  assign dig_port[DIG_LSB +: DIG_W] = in_s.dig;
  assign dig_port[UNIV8_BIT] = in_s.univ8_cmp;

  // address decode of the held location
  wire sel_univ = addr_q == ADDR_UNIV;
  wire sel_misc = addr_q == ADDR_MISC;
  wire sel_dig = addr_q == ADDR_DIG;
  wire sel_exp1 = addr_q == ADDR_EXP_FIRST;
  wire sel_exp2 = addr_q == ADDR_EXP_SECOND;
  wire sel_disp_c = addr_q == ADDR_DISP_CTRL;
  wire sel_disp_d = addr_q == ADDR_DISP_DATA;
  wire sel_exp = sel_exp1 || sel_exp2;
  wire sel_disp = sel_disp_c || sel_disp_d;

  // watchdog and bus-reset locations return zero: the byte has no meaning
  wire [7:0] next_data =
    sel_univ ? univ_port :
    sel_misc ? misc_port :
    sel_dig ? dig_port :
    sel_exp ? in_s.exp_data :
    sel_disp ? in_s.disp_data :
    RST_DATA;

  // drive only decoded locations, 0xC4 and empty space stay released
  wire next_oe = in_read && bird_drives(addr_q);

  // data refreshes every cycle of the read, so a slow display or
  // expansion device only needs its data settled three ref_clk cycles before the strobe rises
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_data_out <= RST_DATA;
      io_data_oe <= 1'b0;
    end else begin
      io_data_out <= in_read ? next_data : RST_DATA;
      io_data_oe <= next_oe;
    end
  end

  // read strobes toward the expansion bus and display module
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      exp_rd_en <= 1'b0;
      exp_rd_second <= 1'b0;
      disp_rd_en <= 1'b0;
      disp_rs <= 1'b0;
    end else begin
      exp_rd_en <= in_read && sel_exp;
      exp_rd_second <= in_read && sel_exp2;
      disp_rd_en <= in_read && sel_disp;
      disp_rs <= in_read && sel_disp_d;
    end
  end

  // side effects fire once per read, at its start
  wire kick_trig = rd_start && (bus_s.addr == ADDR_WATCHDOG);
  wire xrst_trig = rd_start && (bus_s.addr == ADDR_EXP_RESET);

  bird_stretch #(.LEN(WATCHDOG_KICK_CYCLES)) u_kick (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .trig(kick_trig),
    .pulse(watchdog_kick)
  );

  // stretched so slow expansion boards see a clean reset
  bird_stretch #(.LEN(EXP_RST_LEN)) u_xrst (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .trig(xrst_trig),
    .pulse(exp_bus_reset)
  );

  // checks on the decoder
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // a read begins at a given location
  sequence rd_begin(logic [7:0] a);
    (state == ST_IDLE) && !bus_s.rd_n && (bus_s.addr == a);
  endsequence

  // the read strobe is low in this cycle and the next
  sequence rd_held;
    !bus_s.rd_n ##1 !bus_s.rd_n;
  endsequence

  univ_port_a: assert property (
    (io_data_oe && addr_q == ADDR_UNIV) |->
      io_data_out[5:0] == $past(in_s.univ) &&
      io_data_out[6] == $past(in_s.hg_cmp))
    else $error("universal port bits wrong");

  jumper_bit_a: assert property (
    (io_data_oe && addr_q == ADDR_UNIV) |->
      io_data_out[7] == $past(in_s.user_jumper_flag))
    else $error("jumper bit wrong");

  eeprom_bit_a: assert property (
    (io_data_oe && addr_q == ADDR_MISC) |->
      io_data_out[0] == $past(in_s.ee_sda))
    else $error("eeprom data bit wrong");

  misc_port_a: assert property (
    (io_data_oe && addr_q == ADDR_MISC) |->
      io_data_out[1] == $past(in_s.power_fail) &&
      io_data_out[7:2] == $past(in_s.key_col))
    else $error("power fail or keypad bits wrong");

  digital_port_a: assert property (
    (io_data_oe && addr_q == ADDR_DIG) |->
      io_data_out[6:0] == $past(in_s.dig))
    else $error("digital inputs wrong");

  univ8_bit_a: assert property (
    (io_data_oe && addr_q == ADDR_DIG) |->
      io_data_out[7] == $past(in_s.univ8_cmp))
    else $error("channel 8 comparator bit wrong");

  watchdog_kick_a: assert property (
    rd_begin(ADDR_WATCHDOG) |=> watchdog_kick ##1 !watchdog_kick)
    else $error("watchdog kick missing or too long");

  no_kick_a: assert property (
    (!$past(kick_trig) && $rose(watchdog_kick)) |-> 1'b0)
    else $error("watchdog kicked without a read");

  exp_reset_a: assert property (
    rd_begin(ADDR_EXP_RESET) |=> exp_bus_reset[*2])
    else $error("expansion reset not generated");

  exp_first_a: assert property (
    (rd_begin(ADDR_EXP_FIRST) ##0 rd_held) |=>
      exp_rd_en && !exp_rd_second && io_data_oe &&
      io_data_out == $past(in_s.exp_data))
    else $error("first expansion read wrong");

  exp_second_a: assert property (
    (rd_begin(ADDR_EXP_SECOND) ##0 rd_held) |=>
      exp_rd_en && exp_rd_second && io_data_oe)
    else $error("second expansion read wrong");

  unused_loc_a: assert property (
    rd_begin(ADDR_EXP_UNUSED) |-> ##1 !io_data_oe ##1 !io_data_oe)
    else $error("unused location drove the bus");

  disp_ctrl_a: assert property (
    (rd_begin(ADDR_DISP_CTRL) ##0 rd_held) |=>
      disp_rd_en && !disp_rs && io_data_out == $past(in_s.disp_data))
    else $error("display control read wrong");

  disp_data_a: assert property (
    (rd_begin(ADDR_DISP_DATA) ##0 rd_held) |=> disp_rd_en && disp_rs)
    else $error("display data read wrong");

  undecoded_a: assert property (
    io_data_oe |-> bird_drives(addr_q) && !$past(bus_s.rd_n))
    else $error("bus driven outside a decoded read");

  release_a: assert property (
    (state == ST_ACTIVE && bus_s.rd_n) |=> !io_data_oe && !disp_rd_en)
    else $error("bus not released after read");

  // each strobe belongs to its own location and rides with the data
  exp_strobe_a: assert property (
    exp_rd_en |-> io_data_oe &&
      (addr_q == ADDR_EXP_FIRST || addr_q == ADDR_EXP_SECOND))
    else $error("expansion strobe outside its read");

  exp_second_strobe_a: assert property (
    exp_rd_second |-> exp_rd_en && addr_q == ADDR_EXP_SECOND)
    else $error("second expansion strobe without its read");

  disp_strobe_a: assert property (
    disp_rd_en |-> io_data_oe &&
      (addr_q == ADDR_DISP_CTRL || addr_q == ADDR_DISP_DATA))
    else $error("display strobe outside its read");

  disp_select_a: assert property (
    disp_rs |-> disp_rd_en && addr_q == ADDR_DISP_DATA)
    else $error("display data select without its read");

  // a released bus carries no stale byte from the last read
  quiet_bus_a: assert property (
    !io_data_oe |-> io_data_out == RST_DATA)
    else $error("data left on a released bus");

  // the kick byte means nothing, so it must not leak port contents
  kick_byte_a: assert property (
    (io_data_oe && addr_q == ADDR_WATCHDOG) |-> io_data_out == RST_DATA)
    else $error("watchdog read returned port data");

  // how long the expansion reset has stood; only the checks read it
  logic [7:0] xrst_run;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      xrst_run <= 8'h00;
    end else if (xrst_trig || !exp_bus_reset) begin
      xrst_run <= 8'h00;
    end else begin
      xrst_run <= xrst_run + 8'h01;
    end
  end

  exp_reset_len_a: assert property (
    exp_bus_reset |-> 32'(xrst_run) < EXP_RST_LEN)
    else $error("expansion reset stood too long");

  exp_reset_end_a: assert property (
    $fell(exp_bus_reset) |-> 32'(xrst_run) == EXP_RST_LEN)
    else $error("expansion reset ended early");

endmodule // bird_top

// ===== test/bird_cpu_model.sv
`timescale 1ns/1ps
// processor core side: issues i/o reads on the board pins
module bird_cpu_model import bird_pkg::*; (
  // clock
  input wire logic ref_clk,
  // i/o read pins
  output logic [7:0] io_addr,
  output logic io_rd_n,
  // returned byte
  input wire logic [7:0] io_data_out,
  input wire logic io_data_oe
);
  initial begin
    io_addr = 8'h00;
    io_rd_n = 1'b1;
  end

  // address set up three cycles early, strobe held past the answer
  task automatic read(input logic [7:0] a, output logic [7:0] d,
                      output logic oe);
    @(posedge ref_clk);
    io_addr <= a;
    repeat (3) @(posedge ref_clk);
    io_rd_n <= 1'b0;
    repeat (7) @(posedge ref_clk);
    d = io_data_out;
    oe = io_data_oe;
    io_rd_n <= 1'b1;
    // flip the address after release so a stale decode cannot pass
    io_addr <= ~a;
    // reads only: no display command or data is ever sent, busy or not
    repeat (8) @(posedge ref_clk);
  endtask
endmodule // bird_cpu_model

// ===== test/test_board_io_read_decoder.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("FAIL t=%0t got %h exp %h", $time, got, exp); \
  end \
end

module test_board_io_read_decoder import bird_pkg::*; ();
  // short expansion reset ends inside each read window
  localparam int RST_LEN = 4;
  localparam logic [7:0] HIT [9] = '{8'h80, 8'h81, 8'h88, 8'h98,
    8'hC0, 8'hC2, 8'hC6, 8'hD0, 8'hD1};
  localparam logic [7:0] MISS [5] = '{8'hC4, 8'h00, 8'h89, 8'hD8,
    8'hFF};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] io_addr;
  logic [7:0] io_data_out;
  logic io_rd_n;
  logic io_data_oe;
  logic watchdog_kick;
  logic exp_bus_reset;
  logic exp_rd_en;
  logic exp_rd_second;
  logic disp_rd_en;
  logic disp_rs;
  bird_pins_t board_in = '0;
  int failures = 0;
  int compares = 0;
  int seed = 32'hf7b4;
  logic [7:0] kicks;
  logic [7:0] rst_cyc;
  logic [4:0] seen;
  logic [7:0] d;
  logic oe;
  logic [7:0] ra;

  always #5 ref_clk = ~ref_clk;

  bird_top #(.EXP_RST_LEN(RST_LEN)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .io_addr(io_addr),
    .io_rd_n(io_rd_n), .io_data_out(io_data_out),
    .io_data_oe(io_data_oe), .board_in(board_in),
    .watchdog_kick(watchdog_kick), .exp_bus_reset(exp_bus_reset),
    .exp_rd_en(exp_rd_en), .exp_rd_second(exp_rd_second),
    .disp_rd_en(disp_rd_en), .disp_rs(disp_rs));

  bird_cpu_model i_cpu (
    .ref_clk(ref_clk), .io_addr(io_addr), .io_rd_n(io_rd_n),
    .io_data_out(io_data_out), .io_data_oe(io_data_oe));

  // gather pulses and strobes over one read window
  always @(posedge ref_clk) begin
    kicks = kicks + 8'(watchdog_kick);
    rst_cyc = rst_cyc + 8'(exp_bus_reset);
    seen = seen | {io_data_oe, exp_rd_en, exp_rd_second, disp_rd_en,
      disp_rs};
  end

  function automatic logic decoded(input logic [7:0] a);
    return a inside {HIT};
  endfunction

  // byte the processor should see, built field by field
  function automatic logic [7:0] expect_byte(input logic [7:0] a,
                                             input bird_pins_t p);
    case (a)
      8'h80: return {p.user_jumper_flag, p.hg_cmp, p.univ};
      8'h81: return {p.key_col, p.power_fail, p.ee_sda};
      8'h88: return {p.univ8_cmp, p.dig};
      8'hC0, 8'hC2: return p.exp_data;
      8'hD0, 8'hD1: return p.disp_data;
      default: return 8'h00;
    endcase
  endfunction

  task automatic run_read(input logic [7:0] a);
    kicks = 8'h00;
    rst_cyc = 8'h00;
    seen = 5'h00;
    i_cpu.read(a, d, oe);
    `CHK(oe, decoded(a))
    `CHK(seen[4], decoded(a))
    if (decoded(a)) `CHK(d, expect_byte(a, board_in))
    `CHK(kicks, (a == 8'h98) ? 8'h01 : 8'h00)
    `CHK(rst_cyc, (a == 8'hC6) ? 8'(RST_LEN) : 8'h00)
    `CHK(seen[3], a inside {8'hC0, 8'hC2})
    `CHK(seen[2], a == 8'hC2)
    `CHK(seen[1], a inside {8'hD0, 8'hD1})
    `CHK(seen[0], a == 8'hD1)
  endtask

  task automatic close_out;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // corners first (all low, all high), then random board lines
  initial begin
    repeat (16) @(posedge ref_clk);
    `CHK(io_data_oe, 1'b0)
    `CHK(exp_bus_reset, 1'b0)
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int pass = 0; pass < 4; pass++) begin
      @(posedge ref_clk);
      if (pass == 0) board_in <= '0;
      else if (pass == 1) board_in <= '1;
      else board_in <= 40'({$random(seed), $random(seed)});
      foreach (HIT[i]) run_read(HIT[i]);
      foreach (MISS[i]) run_read(MISS[i]);
      ra = 8'($random(seed));
      if (!decoded(ra)) run_read(ra);
      $display("pass %0d done", pass);
    end
    close_out;
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge ref_clk);
    failures++;
    close_out;
  end
endmodule // test_board_io_read_decoder
